/* hdl/bcd_top.sv */
// What this block does
// RULE_01: Shift serial data in, one bit on each falling serial clock edge.
// RULE_02: While deferred update is high, keep shifting but hold all converter outputs.
// RULE_03: Apply pending converter values only on deferred update high-to-low.
// RULE_04: Latch strobe with deferred update low updates the addressed channel at once.
// RULE_05: Keep a separate 8-bit current setting for each of four channels.
// RULE_06: The serial word selects unity or doubled converter gain.
// RULE_07: Each bridge direction follows its own direction input level.
// RULE_08: Regulate each bridge with fixed off-time PWM and mixed decay.
// RULE_09: Host holds data stable before falling clock; full word before latch strobe.
// RULE_10: Word holds channel select, gain bit and 8-bit code, MSB first.
`timescale 1ns/10ps
`default_nettype none

module bcd_top #(
  parameter int unsigned OFF_CYC = bcd_pkg::OFF_CYC,
  parameter int unsigned FAST_CYC = bcd_pkg::FAST_CYC,
  parameter int unsigned BLANK_CYC = bcd_pkg::BLANK_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Serial load pins from the host.
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic word_latch_strobe,
  input wire logic deferred_update_strobe,
  // Direction pins, one per bridge.
  input wire logic bridge1_direction,
  input wire logic bridge2_direction,
  input wire logic bridge3_direction,
  input wire logic bridge4_direction,
  // Current comparator trips from the sense stage.
  input wire logic [bcd_pkg::NUM_CH-1:0] current_trip,
  // Converter settings.
  output logic [bcd_pkg::NUM_CH-1:0][bcd_pkg::CODE_W-1:0] dac_code,
  output logic [bcd_pkg::NUM_CH-1:0] dac_gain_x2,
  // Bridge drive.
  output logic [bcd_pkg::NUM_CH-1:0] bridge_dir,
  output logic [bcd_pkg::NUM_CH-1:0] bridge_on,
  output logic [bcd_pkg::NUM_CH-1:0] bridge_fast_decay
);

  // ************************************************************
  // Word decoding.
  // ************************************************************

  // Channel index carried in the upper field of a word.
  function automatic logic [bcd_pkg::CH_W-1:0] word_channel(
    input logic [bcd_pkg::WORD_W-1:0] w
  );
    word_channel = w[bcd_pkg::CH_LSB +: bcd_pkg::CH_W]; // see RULE_10
  endfunction

  // Gain bit and code of a word.
  function automatic bcd_pkg::bcd_setting_s word_setting(
    input logic [bcd_pkg::WORD_W-1:0] w
  );
    bcd_pkg::bcd_setting_s s;
    s.gain_x2 = w[bcd_pkg::GAIN_POS]; // see RULE_06
    s.code = w[bcd_pkg::CODE_LSB +: bcd_pkg::CODE_W]; // see RULE_10
    word_setting = s;
  endfunction

  // A synchronised level that was high one clock ago and is low now.
  function automatic logic went_low(
    input logic prev_lvl,
    input logic cur_lvl
  );
    went_low = prev_lvl & ~cur_lvl;
  endfunction

  // The rising counterpart, used for the word latch strobe.
  function automatic logic went_high(
    input logic prev_lvl,
    input logic cur_lvl
  );
    went_high = ~prev_lvl & cur_lvl;
  endfunction

  // ************************************************************
  // State.
  // ************************************************************

  // Everything the block remembers outside the regulators lives in one register, so reset and
  // clocking stay in a single process and no field can be left out of reset.
  // The settings are kept as plain vectors and viewed through the struct type.
  typedef struct packed {
    bcd_pkg::bcd_pins_s sync1;
    bcd_pkg::bcd_pins_s sync2;
    logic clk_prev;
    logic latch_prev;
    logic update_prev;
    logic [bcd_pkg::WORD_W-1:0] shift;
    logic [bcd_pkg::NUM_CH-1:0][$bits(bcd_pkg::bcd_setting_s)-1:0] pend;
    logic [bcd_pkg::NUM_CH-1:0][$bits(bcd_pkg::bcd_setting_s)-1:0] live;
    logic [bcd_pkg::NUM_CH-1:0] dir;
    logic [bcd_pkg::NUM_CH-1:0] enable;
  } bcd_top_s;

  bcd_top_s r, n;
  bcd_pkg::bcd_pins_s pins;
  logic clk_fall;
  logic latch_rise;
  logic update_fall;
  logic [bcd_pkg::CH_W-1:0] sel_ch;
  bcd_pkg::bcd_setting_s new_set;
  bcd_pkg::bcd_setting_s cur_set;

  // Neutral value that the per-channel loop variable starts from, so the
  // combinational process never leaves it unassigned on any path.
  localparam bcd_pkg::bcd_setting_s SETTING_RST_L = bcd_pkg::SETTING_RST;

  // ************************************************************
  // Pin capture and edge detection.
  // ************************************************************

  // Gather every asynchronous pin so they cross together through two flops.
  always_comb begin
    pins.ser_clk = ser_clk;
    pins.ser_data = ser_data;
    pins.word_latch = word_latch_strobe;
    pins.deferred_update = deferred_update_strobe;
    pins.dir = {bridge4_direction, bridge3_direction, bridge2_direction, bridge1_direction};
    pins.trip = current_trip;
  end

  // Edge detectors look only at the second stage and its delayed copy; both
  // copies reset low, so the idle-high serial clock cannot fake a fall at start.
  assign clk_fall = went_low(r.clk_prev, r.sync2.ser_clk);
  assign latch_rise = went_high(r.latch_prev, r.sync2.word_latch);
  assign update_fall = went_low(r.update_prev, r.sync2.deferred_update);
  assign sel_ch = word_channel(r.shift);
  assign new_set = word_setting(r.shift);

  // ************************************************************
  // Next-state logic.
  // ************************************************************

  // Limits that the host must keep to:
  // - Each half period of the serial clock must last longer than one core clock,
  //   or a short pulse can fall between two samples and a bit is lost.
  // - Only the last eleven bits shifted before a latch strobe count; a longer
  //   frame simply pushes the oldest bits out.
  // - A latch strobe acts on the third core clock after its pin rises, so the
  //   last bit must be shifted before the strobe is raised.
  // - There is no frame marker: a host that loses count must resend a full word.

  // Data is sampled on the same synchronised edge as the clock; the host keeps
  // it stable around the falling edge, which the 80 ns link period allows.
  always_comb begin
    n = r;
    cur_set = SETTING_RST_L;
    n.sync1 = pins;
    n.sync2 = r.sync1;
    n.clk_prev = r.sync2.ser_clk;
    n.latch_prev = r.sync2.word_latch;
    n.update_prev = r.sync2.deferred_update;
    if (clk_fall) begin
      n.shift = {r.shift[bcd_pkg::WORD_W-2:0], r.sync2.ser_data}; // see RULE_01
    end
    // A strobe stores the word as pending for its channel in every case.
    if (latch_rise) begin
      n.pend[sel_ch] = new_set; // see RULE_05
      if (!r.sync2.deferred_update) begin
        n.live[sel_ch] = new_set; // see RULE_04
      end
    end
    // Held outputs move only on the falling edge of the deferred update pin,
    // taking any word latched in the same cycle as well.
    if (update_fall) begin
      n.live = n.pend; // see RULE_03
    end else if (r.sync2.deferred_update && !latch_rise) begin
      n.live = r.live; // see RULE_02
    end
    n.dir = r.sync2.dir; // see RULE_07
    // A zero code asks for no current, so the bridge idles.
    for (int i = 0; i < bcd_pkg::NUM_CH; i++) begin
      cur_set = r.live[i];
      n.enable[i] = (cur_set.code != '0);
    end
  end

  // State register; reset clears every setting so no bridge drives.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // Outputs and per-bridge regulators.
  // ************************************************************

  // One regulator per bridge: a trip on one channel never shortens the
  // off-time of another, at the cost of four copies of the counter logic.
  // The enable lags the live code by one clock, which the regulator tolerates.
  for (genvar g = 0; g < bcd_pkg::NUM_CH; g++) begin : g_ch
    bcd_pkg::bcd_setting_s out_set;
    assign out_set = r.live[g];
    assign dac_code[g] = out_set.code; // see RULE_05
    assign dac_gain_x2[g] = out_set.gain_x2; // see RULE_06
    assign bridge_dir[g] = r.dir[g]; // see RULE_07

    // Trip is read from the second synchroniser stage only.
    bcd_pwm #(
      .OFF_CYC(OFF_CYC),
      .FAST_CYC(FAST_CYC),
      .BLANK_CYC(BLANK_CYC)
    ) u_pwm (
      .core_clk(core_clk),
      .rst(rst),
      .enable(r.enable[g]),
      .trip(r.sync2.trip[g]),
      .drive_on(bridge_on[g]),
      .fast_decay(bridge_fast_decay[g])
    ); // see RULE_08
  end

endmodule // bcd_top

`default_nettype wire

/* hdl/bcd_pkg.sv */
package bcd_pkg;

  // ************************************************************
  // Sizes of the channel array and the serial word.
  // ************************************************************
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned CH_W = 2;
  localparam int unsigned WORD_W = CH_W + 1 + CODE_W;

  // Field positions inside the shifted word, sent most significant bit first.
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned GAIN_POS = CODE_W;
  localparam int unsigned CH_LSB = CODE_W + 1;

  // ************************************************************
  // Timing of the current regulator.
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OFF_TIME_NS = 25000;
  localparam int unsigned FAST_DECAY_NS = 7500;
  localparam int unsigned BLANK_NS = 1200;
  // The off-time is a longest time, so it rounds down; blanking is a least time.
  localparam int unsigned OFF_CYC = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_CYC = FAST_DECAY_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWM_CNT_W = 12;

  // ************************************************************
  // Types.
  // ************************************************************
  typedef struct packed {
    logic gain_x2;
    logic [CODE_W-1:0] code;
  } bcd_setting_s;

  localparam bcd_setting_s SETTING_RST = '0;

  // Every pin that crosses into the core clock domain.
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic word_latch;
    logic deferred_update;
    logic [NUM_CH-1:0] dir;
    logic [NUM_CH-1:0] trip;
  } bcd_pins_s;

  typedef enum logic [1:0] {
    PWM_IDLE,
    PWM_ON,
    PWM_FAST,
    PWM_SLOW
  } bcd_pwm_e;

  typedef struct packed {
    bcd_pwm_e state;
    logic [PWM_CNT_W-1:0] cnt;
    logic on;
    logic fast;
  } bcd_pwm_s;

endpackage

/* hdl/bcd_pwm.sv */
`timescale 1ns/10ps
`default_nettype none

module bcd_pwm #(
  parameter int unsigned OFF_CYC = bcd_pkg::OFF_CYC,
  parameter int unsigned FAST_CYC = bcd_pkg::FAST_CYC,
  parameter int unsigned BLANK_CYC = bcd_pkg::BLANK_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Regulation control, already synchronised.
  input wire logic enable,
  input wire logic trip,
  // Bridge drive.
  output logic drive_on,
  output logic fast_decay
);

  bcd_pkg::bcd_pwm_s r, n;

  // One fixed off-time per trip: fast decay first, then slow decay for the rest.
  always_comb begin
    n = r;
    case (r.state)
      bcd_pkg::PWM_IDLE: begin
        n.on = 1'b0;
        n.fast = 1'b0;
        if (enable) begin
          n.state = bcd_pkg::PWM_ON;
          n.cnt = '0;
          n.on = 1'b1;
        end
      end
      bcd_pkg::PWM_ON: begin
        // The trip is ignored while blanked, so switching spikes cannot end the phase.
        if (r.cnt < bcd_pkg::PWM_CNT_W'(BLANK_CYC)) begin
          n.cnt = r.cnt + 1'b1;
        end
        if (!enable) begin
          n.state = bcd_pkg::PWM_IDLE;
          n.on = 1'b0;
        end else if (trip && r.cnt >= bcd_pkg::PWM_CNT_W'(BLANK_CYC)) begin // see RULE_08
          n.state = bcd_pkg::PWM_FAST;
          n.cnt = '0;
          n.on = 1'b0;
          n.fast = 1'b1;
        end
      end
      bcd_pkg::PWM_FAST: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == bcd_pkg::PWM_CNT_W'(FAST_CYC - 1)) begin // see RULE_08
          n.state = bcd_pkg::PWM_SLOW;
          n.fast = 1'b0;
        end
      end
      bcd_pkg::PWM_SLOW: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == bcd_pkg::PWM_CNT_W'(OFF_CYC - 1)) begin // see RULE_08
          n.cnt = '0;
          n.state = enable ? bcd_pkg::PWM_ON : bcd_pkg::PWM_IDLE;
          n.on = enable;
        end
      end
      default: begin
        n = '0;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign drive_on = r.on;
  assign fast_decay = r.fast;

endmodule // bcd_pwm

`default_nettype wire

/* tb/bcd_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ******
// Port checker.
// ******
module bcd_checker #(
  parameter int unsigned FAST_CYC = bcd_pkg::FAST_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Host pins.
  input wire logic word_latch_strobe,
  input wire logic deferred_update_strobe,
  input wire logic bridge1_direction,
  input wire logic bridge2_direction,
  input wire logic bridge3_direction,
  input wire logic bridge4_direction,
  // Outputs.
  input wire logic [bcd_pkg::NUM_CH-1:0][bcd_pkg::CODE_W-1:0] dac_code,
  input wire logic [bcd_pkg::NUM_CH-1:0] dac_gain_x2,
  input wire logic [bcd_pkg::NUM_CH-1:0] bridge_dir,
  input wire logic [bcd_pkg::NUM_CH-1:0] bridge_on,
  input wire logic [bcd_pkg::NUM_CH-1:0] bridge_fast_decay
);
  logic [1:0] age_r;
  logic [3:0] hi_r;
  logic [3:0] lo_r;
  logic [3:0] ev_r;
  logic [11:0] fc_r;
  logic [bcd_pkg::NUM_CH-1:0][bcd_pkg::CODE_W-1:0] code_r;
  logic [3:0] chg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Counters other than fc_r saturate, so a long run never wraps into a false window.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      age_r <= '0;
      hi_r <= '0;
      lo_r <= '0;
      ev_r <= '0;
      fc_r <= '0;
      code_r <= '0;
    end else begin
      age_r <= (&age_r) ? age_r : age_r + 2'h1;
      hi_r <= !deferred_update_strobe ? 4'h0 : (&hi_r) ? hi_r : hi_r + 4'h1;
      lo_r <= deferred_update_strobe ? 4'h0 : (&lo_r) ? lo_r : lo_r + 4'h1;
      ev_r <= (word_latch_strobe || deferred_update_strobe) ? 4'h0 : (&ev_r) ? ev_r : ev_r + 4'h1;
      fc_r <= bridge_fast_decay[0] ? fc_r + 12'h001 : 12'h000;
      code_r <= dac_code;
    end
  end
  // Channels whose code moved on this edge.
  assign chg = {dac_code[3] != code_r[3], dac_code[2] != code_r[2],
    dac_code[1] != code_r[1], dac_code[0] != code_r[0]};
  property p_dir; age_r == 2'h3 |-> bridge_dir == {$past(bridge4_direction, 3),
    $past(bridge3_direction, 3), $past(bridge2_direction, 3), $past(bridge1_direction, 3)}; endproperty
  a_dir: assert property (p_dir) else $error("direction lag wrong");
  property p_hold; hi_r >= 4'h6 |-> $stable(dac_code) && $stable(dac_gain_x2); endproperty
  a_hold: assert property (p_hold) else $error("output moved while held");
  property p_cause; $changed(dac_code) || $changed(dac_gain_x2) |-> ev_r <= 4'h7; endproperty
  a_cause: assert property (p_cause) else $error("output moved unasked");
  property p_one; lo_r >= 4'h8 |-> $onehot0(chg); endproperty
  a_one: assert property (p_one) else $error("several channels moved");
  property p_excl; (bridge_on & bridge_fast_decay) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("on during decay");
  property p_fast; fc_r <= FAST_CYC; endproperty
  a_fast: assert property (p_fast) else $error("fast decay too long");
  property p_enter; $rose(bridge_fast_decay[0]) |-> $past(bridge_on[0]); endproperty
  a_enter: assert property (p_enter) else $error("decay without on phase");
  property p_on0; $rose(bridge_on[0]) |-> $past(dac_code[0], 2) != 8'h00; endproperty
  a_on0: assert property (p_on0) else $error("drive with zero code");
endmodule // bcd_checker

bind bcd_top bcd_checker #(.FAST_CYC(FAST_CYC)) u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .word_latch_strobe(word_latch_strobe),
  .deferred_update_strobe(deferred_update_strobe),
  .bridge1_direction(bridge1_direction),
  .bridge2_direction(bridge2_direction),
  .bridge3_direction(bridge3_direction),
  .bridge4_direction(bridge4_direction),
  .dac_code(dac_code),
  .dac_gain_x2(dac_gain_x2),
  .bridge_dir(bridge_dir),
  .bridge_on(bridge_on),
  .bridge_fast_decay(bridge_fast_decay)
);
`default_nettype wire

/* tb/bcd_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ******
// Host model for the serial load pins.
// ******
module bcd_host (
  // Serial load pins.
  output logic ser_clk,
  output logic ser_data,
  output logic word_latch_strobe
);
  // The serial clock idles high and runs only inside a frame.
  initial begin
    ser_clk = 1'b1;
    ser_data = 1'b0;
    word_latch_strobe = 1'b0;
  end
  // Bits go out most significant first, each steady around its falling edge.
  task automatic send(input logic [bcd_pkg::WORD_W-1:0] w);
    for (int i = bcd_pkg::WORD_W - 1; i >= 0; i--) begin
      ser_data = w[i];
      #20 ser_clk = 1'b0;
      #40 ser_clk = 1'b1;
      #20;
    end
    // No pull on the data line, so it shows the inverse once released.
    ser_data = ~w[0];
    #40 word_latch_strobe = 1'b1;
    #80 word_latch_strobe = 1'b0;
    #40;
  endtask
endmodule // bcd_host
`default_nettype wire

/* tb/test_bridge_current_dac_serial_load.sv */
`timescale 1ns/10ps
`default_nettype none
// ******
// Self-checking bench.
// ******
module test_bridge_current_dac_serial_load;
  localparam int unsigned OFF = 20;
  localparam int unsigned FAST = 6;
  logic core_clk;
  logic rst;
  logic ser_clk;
  logic ser_data;
  logic latch;
  logic upd;
  logic [3:0] dir;
  logic [3:0] trip;
  logic [3:0][7:0] code;
  logic [3:0] gain;
  logic [3:0] bdir;
  logic [3:0] bon;
  logic [3:0] bfast;
  int errors;
  int n_checks;
  int cde[4];
  int gn[4];
  int pc[4];
  int pg[4];
  int n;
  int t;
  bcd_host host (.ser_clk(ser_clk), .ser_data(ser_data), .word_latch_strobe(latch));
  bcd_top #(.OFF_CYC(OFF), .FAST_CYC(FAST), .BLANK_CYC(3)) DUT (
    .core_clk(core_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .word_latch_strobe(latch), .deferred_update_strobe(upd),
    .bridge1_direction(dir[0]), .bridge2_direction(dir[1]),
    .bridge3_direction(dir[2]), .bridge4_direction(dir[3]), .current_trip(trip),
    .dac_code(code), .dac_gain_x2(gain), .bridge_dir(bdir), .bridge_on(bon),
    .bridge_fast_decay(bfast));
  // Clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compares every channel with the model.
  task automatic cmp_all();
    for (int c = 0; c < 4; c++) begin
      check(code[c], cde[c]);
      check(gain[c], gn[c]);
    end
  endtask
  // A latch while held only fills the pending copy.
  task automatic load(input int c, input int v, input int g);
    pc[c] = v;
    pg[c] = g;
    if (!upd) begin
      cde[c] = v;
      gn[c] = g;
    end
    host.send({c[1:0], g[0], v[7:0]});
    @(negedge core_clk);
    cmp_all();
  endtask
  // Watchdog well beyond the expected run of about 11 us.
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    upd = 1'b0;
    dir = 4'h0;
    trip = 4'h0;
    errors = 0;
    n_checks = 0;
    n = $urandom(87654);
    for (int c = 0; c < 4; c++) begin
      cde[c] = 0;
      gn[c] = 0;
      pc[c] = 0;
      pg[c] = 0;
    end
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    cmp_all();
    // Every channel with both gains, back to back.
    for (int i = 0; i < 8; i++) load(i % 4, $urandom_range(255, 1), i / 4);
    upd = 1'b1;
    load(1, $urandom_range(255, 1), 1);
    load(2, $urandom_range(255, 1), 0);
    @(negedge core_clk);
    upd = 1'b0;
    repeat (8) @(negedge core_clk);
    for (int c = 0; c < 4; c++) begin
      cde[c] = pc[c];
      gn[c] = pg[c];
    end
    cmp_all();
    for (int i = 0; i < 4; i++) begin
      dir = 4'($urandom);
      repeat (5) @(negedge core_clk);
      check(bdir, dir);
    end
    // Trip channel 0 once its on phase is past blanking, then time the off phase.
    for (n = 0; n < 100 && bon[0] !== 1'b1; n++) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
    trip[0] = 1'b1;
    for (n = 0; n < 20 && bfast[0] !== 1'b1; n++) @(negedge core_clk);
    trip[0] = 1'b0;
    for (n = 0; n < 100 && bfast[0] === 1'b1; n++) @(negedge core_clk);
    check(n, FAST);
    for (t = n; t < 100 && bon[0] !== 1'b1; t++) @(negedge core_clk);
    check(t, OFF);
    stop_test();
  end
endmodule // test_bridge_current_dac_serial_load
`default_nettype wire
